// >>> design/phy_cfg_pkg.sv
// constants and types of the strap and negotiation configuration block
package phy_cfg_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0]  IDX_CTRL      = 6'h00;
   localparam logic [5:0]  IDX_STATUS    = 6'h01;
   localparam logic [5:0]  IDX_ADV       = 6'h04;
   localparam logic [5:0]  IDX_PARTNER   = 6'h05;
   localparam logic [5:0]  IDX_EXPANSION = 6'h06;
   localparam logic [5:0]  IDX_LINK      = 6'h10;
   localparam logic [5:0]  IDX_PORT_CFG  = 6'h19;
   // control fields
   localparam int CTRL_SPEED   = 13;
   localparam int CTRL_NEGOTIATE_ENABLE_STRAP   = 12;
   localparam int CTRL_ISOLATE = 10;
   localparam int CTRL_RESTART = 9;
   localparam int CTRL_DUPLEX  = 8;
   // advertisement and partner fields
   localparam int ADV_NP       = 15;
   localparam int ADV_RFAULT   = 13;
   localparam int ADV_LO       = 5;
   localparam logic [4:0]  ADV_SELECTOR = 5'h01;
   // status fields
   localparam logic [15:0] STATUS_FIXED = 16'h7849;
   localparam int STATUS_AN_DONE = 5;
   localparam int STATUS_RFAULT  = 4;
   localparam int STATUS_LINK    = 2;
   // port config fields
   localparam int CFG_XOVER  = 15;
   localparam int CFG_ENERGY = 14;
   localparam int CFG_LAMP   = 5;
   // parallel detect partner words
   localparam logic [15:0] PD_WORD_100 = 16'h0081;
   localparam logic [15:0] PD_WORD_10  = 16'h0021;

   typedef enum logic [1:0] {
      MAC_MII    = 2'b00,
      MAC_RMII   = 2'b01,
      MAC_SERIAL = 2'b10
   } mac_mode_type;

   typedef struct packed {
      logic if_mode;
      logic serial;
      logic lamp;
      logic xover;
      logic energy;
      logic clk_dis;
      logic extender;
      logic negotiate_enable_strap;
      logic ab_hi;
      logic ab_lo;
   } strap_type;

   typedef struct packed {
      logic link;
      logic speed100;
      logic full;
   } op_mode_type;
endpackage

// >>> design/phy_strap_autoneg_config.sv
// strap capture, negotiation setup and management registers of one port
`timescale 1ns/1ps
module phy_strap_autoneg_config
   import phy_cfg_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // apb slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // strap pins and wire activity
   input  wire strap_type    strap_pins,
   input  wire logic         wire_activity,
   // negotiation engine events
   input  wire logic         link_ok,
   input  wire logic         page_valid,
   input  wire logic [15:0]  page_word,
   input  wire logic         pd_link_100,
   input  wire logic         pd_link_10,
   input  wire logic         pd_fault,
   // configuration outputs
   output mac_mode_type      mac_mode,
   output logic              single_clock_mii,
   output logic [1:0]        lamp_cfg,
   output logic              auto_crossover,
   output logic              low_power,
   output logic              refclk_out,
   output logic              refclk_out_oe,
   output logic              flp_enable,
   output logic [15:0]       adv_word,
   output logic              restart_pulse,
   output logic              isolate,
   output op_mode_type       op_mode
);

   function automatic logic [3:0] adv_from_straps(input strap_type s);
      logic [1:0] sel;
      sel = {s.ab_hi, s.ab_lo};
      if (!s.negotiate_enable_strap) begin
         adv_from_straps = 4'h1 << sel;
      end else begin
         case (sel)
            2'b00:   adv_from_straps = 4'h3;
            2'b01:   adv_from_straps = 4'hc;
            2'b10:   adv_from_straps = 4'h5;
            default: adv_from_straps = 4'hf;
         endcase
      end
   endfunction

   // synchronisers; only the second stage is read
   strap_type   strap_s1_ff;
   strap_type   strap_s2_ff;
   logic        wire_s1_ff;
   logic        wire_s2_ff;

   always_ff @(posedge clock) begin
      strap_s1_ff <= strap_pins;
      strap_s2_ff <= strap_s1_ff;
      wire_s1_ff  <= wire_activity;
      wire_s2_ff  <= wire_s1_ff;
   end

   // state
   logic [15:0] ctrl_ff;
   logic [15:0] adv_ff;
   logic [15:0] partner_ff;
   logic [15:0] cfg_ff;
   logic [3:0]  lp_base_ff;
   logic        base_wait_ff;
   logic        an_done_ff;
   logic        page_rx_ff;
   logic        pd_fault_ff;
   logic        lp_able_ff;
   logic        if_mode_ff;
   logic        serial_ff;
   logic        extender_ff;
   logic        clk_dis_ff;
   logic        low_power_ff;
   logic        refclk_ff;
   logic        restart_ff;
   logic [31:0] prdata_ff;

   // bus decode
   wire         setup_rd  = psel & ~penable & ~pwrite;
   wire         access    = psel & penable;
   wire         wr_fire   = access & pwrite;
   wire         rd_fire   = access & ~pwrite;
   wire [5:0]   idx       = paddr[7:2];
   wire         hit_ctrl  = idx == IDX_CTRL;
   wire         hit_adv   = idx == IDX_ADV;
   wire         hit_cfg   = idx == IDX_PORT_CFG;
   wire         hit_exp   = idx == IDX_EXPANSION;
   wire         hit_any   = hit_ctrl | hit_adv | hit_cfg | hit_exp | idx == IDX_STATUS |
                            idx == IDX_PARTNER | idx == IDX_LINK;
   wire         wr_ctrl   = wr_fire & hit_ctrl;
   wire         wr_adv    = wr_fire & hit_adv;
   wire         wr_cfg    = wr_fire & hit_cfg;
   wire         rd_exp    = rd_fire & hit_exp;

   // reset images of the strapped registers
   wire         st_an     = strap_s2_ff.negotiate_enable_strap;
   wire [15:0]  ctrl_rst  = {2'b00, st_an | strap_s2_ff.ab_hi, st_an, 3'b000,
                             st_an | strap_s2_ff.ab_lo, 8'h00};
   wire [15:0]  adv_rst   = {7'h00, adv_from_straps(strap_s2_ff), ADV_SELECTOR};
   wire [15:0]  cfg_rst   = {strap_s2_ff.xover, strap_s2_ff.energy, 7'h00,
                             1'b0, strap_s2_ff.lamp, 5'h00};

   // resolution of the highest common ability
   wire         negotiate_enable_strap     = ctrl_ff[CTRL_NEGOTIATE_ENABLE_STRAP];
   wire [3:0]   common    = adv_ff[ADV_LO+3:ADV_LO] & lp_base_ff;
   wire         res_100   = common[3] | common[2];
   wire         res_full  = common[3] | (~common[2] & common[1]);
   wire         spd_100   = negotiate_enable_strap ? an_done_ff & res_100 : ctrl_ff[CTRL_SPEED];
   wire         dup_full  = negotiate_enable_strap ? an_done_ff & res_full : ctrl_ff[CTRL_DUPLEX];
   wire         last_page = page_valid & ~page_word[ADV_NP];
   wire         pd_any    = pd_link_100 | pd_link_10;

   // read words
   wire [15:0]  status_w  = STATUS_FIXED |
                            (16'(an_done_ff) << STATUS_AN_DONE) |
                            (16'(partner_ff[ADV_RFAULT]) << STATUS_RFAULT) |
                            (16'(link_ok) << STATUS_LINK);
   wire [15:0]  exp_w     = {11'h000, pd_fault_ff, partner_ff[ADV_NP], 1'b1,
                             page_rx_ff, lp_able_ff};
   wire [15:0]  link_w    = {11'h000, an_done_ff, 1'b0, dup_full, ~spd_100, link_ok};
   wire [15:0]  rd_word   = hit_ctrl ? ctrl_ff :
                            idx == IDX_STATUS ? status_w :
                            hit_adv ? adv_ff :
                            idx == IDX_PARTNER ? partner_ff :
                            hit_exp ? exp_w :
                            idx == IDX_LINK ? link_w :
                            hit_cfg ? cfg_ff : 16'h0000;

   // control register; restart bit self clears into a pulse
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_ff    <= ctrl_rst;
         restart_ff <= 1'b0;
      end else begin
         restart_ff <= wr_ctrl & pwdata[CTRL_RESTART];
         if (wr_ctrl) begin
            ctrl_ff <= pwdata[15:0] & 16'h3500;
         end
      end
   end

   // advertisement: abilities, remote fault and next page writable, selector fixed
   always_ff @(posedge clock) begin
      if (rst) begin
         adv_ff <= adv_rst;
      end else if (wr_adv) begin
         adv_ff <= {pwdata[15:5] & 11'h50f, ADV_SELECTOR};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_ff <= cfg_rst;
      end else if (wr_cfg) begin
         cfg_ff <= pwdata[15:0] & 16'hc060;
      end
   end

   // partner word and negotiation progress
   always_ff @(posedge clock) begin
      if (rst) begin
         partner_ff   <= 16'h0000;
         lp_base_ff   <= 4'h0;
         base_wait_ff <= 1'b1;
         an_done_ff   <= 1'b0;
         lp_able_ff   <= 1'b0;
      end else if (restart_ff | ~negotiate_enable_strap) begin
         base_wait_ff <= 1'b1;
         an_done_ff   <= 1'b0;
      end else if (page_valid) begin
         partner_ff   <= page_word;
         base_wait_ff <= 1'b0;
         lp_able_ff   <= 1'b1;
         if (base_wait_ff) begin
            lp_base_ff <= page_word[ADV_LO+3:ADV_LO];
         end
         if (last_page) begin
            an_done_ff <= 1'b1;
         end
      end else if (pd_any) begin
         partner_ff   <= pd_link_100 ? PD_WORD_100 : PD_WORD_10;
         lp_base_ff   <= pd_link_100 ? 4'h4 : 4'h1;
         lp_able_ff   <= 1'b0;
         an_done_ff   <= 1'b1;
      end
   end

   // sticky expansion flags, cleared by a read; a new event wins over the clear
   always_ff @(posedge clock) begin
      if (rst) begin
         page_rx_ff  <= 1'b0;
         pd_fault_ff <= 1'b0;
      end else begin
         page_rx_ff  <= page_valid | (page_rx_ff & ~rd_exp);
         pd_fault_ff <= pd_fault | (pd_fault_ff & ~rd_exp);
      end
   end

   // pin straps that have no register
   always_ff @(posedge clock) begin
      if (rst) begin
         if_mode_ff  <= strap_s2_ff.if_mode;
         serial_ff   <= strap_s2_ff.serial;
         extender_ff <= strap_s2_ff.extender;
         clk_dis_ff  <= strap_s2_ff.clk_dis;
      end
   end

   // low power leaves only on wire activity or when software drops energy detect
   always_ff @(posedge clock) begin
      if (rst) begin
         low_power_ff <= strap_s2_ff.energy;
      end else if (wire_s2_ff | ~cfg_ff[CFG_ENERGY]) begin
         low_power_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         refclk_ff <= 1'b0;
      end else begin
         refclk_ff <= ~refclk_ff;
      end
   end

   // read data is set up in the setup phase so the access phase needs no wait
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata_ff <= {16'h0000, rd_word};
      end
   end

   // serial wins if the board breaks the extender exclusion
   assign mac_mode         = !if_mode_ff ? MAC_MII : serial_ff ? MAC_SERIAL : MAC_RMII;
   assign single_clock_mii = extender_ff & ~if_mode_ff;
   assign lamp_cfg         = cfg_ff[CFG_LAMP+1:CFG_LAMP];
   assign auto_crossover   = cfg_ff[CFG_XOVER];
   assign low_power        = low_power_ff;
   assign refclk_out       = refclk_ff;
   assign refclk_out_oe    = ~clk_dis_ff;
   assign flp_enable       = negotiate_enable_strap & ~restart_ff;
   assign adv_word         = adv_ff;
   assign restart_pulse    = restart_ff;
   assign isolate          = ctrl_ff[CTRL_ISOLATE];
   assign op_mode          = '{link: link_ok, speed100: spd_100, full: dup_full};
   assign prdata           = prdata_ff;
   assign pready           = access;
   assign pslverr          = access & ~hit_any;

   a_adv_strap_load: assert property (@(posedge clock) disable iff (rst)
      $fell(rst) |-> adv_ff[ADV_LO+3:ADV_LO] == adv_from_straps($past(strap_s2_ff)))
      else $error("advertisement not loaded from straps");

   a_forced_mode: assert property (@(posedge clock) disable iff (rst)
      !negotiate_enable_strap |-> op_mode.speed100 == ctrl_ff[CTRL_SPEED] && op_mode.full == ctrl_ff[CTRL_DUPLEX])
      else $error("forced mode does not follow control bits");

   a_priority_top: assert property (@(posedge clock) disable iff (rst)
      negotiate_enable_strap && an_done_ff && common[3] |-> op_mode.speed100 && op_mode.full)
      else $error("common 100 full not chosen");

   a_pd_word: assert property (@(posedge clock) disable iff (rst)
      negotiate_enable_strap && !restart_ff && !page_valid && pd_link_100 |=> partner_ff == PD_WORD_100)
      else $error("parallel detect word not loaded");

   a_wake_activity: assert property (@(posedge clock) disable iff (rst)
      wire_s2_ff |=> !low_power)
      else $error("low power kept after wire activity");

   a_refclk_runs: assert property (@(posedge clock) disable iff (rst)
      refclk_out_oe ##1 refclk_out_oe |-> refclk_out != $past(refclk_out))
      else $error("reference clock output not toggling");

   a_status_fixed: assert property (@(posedge clock) disable iff (rst)
      setup_rd && idx == IDX_STATUS |=> (prdata[15:0] & 16'hf849) == STATUS_FIXED)
      else $error("fixed status ability bits wrong");

   a_page_sticky: assert property (@(posedge clock) disable iff (rst)
      page_valid ##1 !rd_exp |=> page_rx_ff)
      else $error("page received flag lost");

   a_ctrl_write: assert property (@(posedge clock) disable iff (rst)
      wr_ctrl |=> ctrl_ff[CTRL_NEGOTIATE_ENABLE_STRAP] == $past(pwdata[CTRL_NEGOTIATE_ENABLE_STRAP]) ##1 !restart_ff)
      else $error("control write not applied");

   a_single_clock: assert property (@(posedge clock) disable iff (rst)
      single_clock_mii |-> mac_mode == MAC_MII)
      else $error("single clock outside MII mode");

   a_restart_once: assert property (@(posedge clock) disable iff (rst)
      wr_ctrl && pwdata[CTRL_RESTART] |=> restart_pulse && !flp_enable)
      else $error("restart pulse missing or link pulses not held");

   a_adv_write: assert property (@(posedge clock) disable iff (rst)
      wr_adv |=> adv_word[ADV_LO+3:ADV_LO] == $past(pwdata[ADV_LO+3:ADV_LO]) &&
                 adv_word[ADV_LO-1:0] == ADV_SELECTOR)
      else $error("advertised abilities not written");

   a_page_capture: assert property (@(posedge clock) disable iff (rst)
      negotiate_enable_strap && !restart_ff && page_valid |=> partner_ff == $past(page_word))
      else $error("received page not captured");

   a_pd_word_10: assert property (@(posedge clock) disable iff (rst)
      negotiate_enable_strap && !restart_ff && !page_valid && !pd_link_100 && pd_link_10 |=>
         partner_ff == PD_WORD_10)
      else $error("parallel detect 10 word not loaded");

   a_an_off_clears: assert property (@(posedge clock) disable iff (rst)
      !negotiate_enable_strap |=> !status_w[STATUS_AN_DONE])
      else $error("negotiation done kept while negotiation off");

   a_pd_fault_sticky: assert property (@(posedge clock) disable iff (rst)
      pd_fault |=> pd_fault_ff)
      else $error("parallel detect fault not flagged");

   a_exp_read_clear: assert property (@(posedge clock) disable iff (rst)
      rd_exp && !page_valid |=> !page_rx_ff)
      else $error("page received flag not cleared by read");

   a_priority_low: assert property (@(posedge clock) disable iff (rst)
      negotiate_enable_strap && an_done_ff && common == 4'h1 |-> !op_mode.speed100 && !op_mode.full)
      else $error("only common 10 half not chosen");

   a_link_read: assert property (@(posedge clock) disable iff (rst)
      setup_rd && idx == IDX_LINK |=>
         prdata[0] == $past(link_ok) && prdata[1] != $past(spd_100))
      else $error("link status read word wrong");

   a_strap_frozen: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) |->
         $stable(mac_mode) && $stable(single_clock_mii) && $stable(refclk_out_oe))
      else $error("strapped configuration changed outside reset");

   a_low_power_once: assert property (@(posedge clock) disable iff (rst)
      !low_power |=> !low_power)
      else $error("low power state entered again");

   a_lamp_mode: assert property (@(posedge clock) disable iff (rst)
      $fell(rst) |-> !lamp_cfg[1])
      else $error("lamp strap selected a register only mode");

endmodule // phy_strap_autoneg_config

// >>> bench/link_partner_model.sv
// link partner model that offers code words and parallel detect results
`timescale 1ns/1ps
module link_partner_model (
   // clock
   input  wire logic         clock,
   // negotiation events toward the port
   output logic              link_ok,
   output logic              page_valid,
   output logic [15:0]       page_word,
   output logic              pd_link_100,
   output logic              pd_link_10,
   output logic              pd_fault
);
   initial begin
      link_ok     = 1'b0;
      page_valid  = 1'b0;
      page_word   = 16'hffff;
      pd_link_100 = 1'b0;
      pd_link_10  = 1'b0;
      pd_fault    = 1'b0;
   end

   task automatic set_link(input logic v);
      @(posedge clock);
      link_ok <= v;
   endtask

   // a word is valid for one edge only; afterwards the lines show its inverse
   task automatic send_page(input logic [15:0] w);
      @(posedge clock);
      page_valid <= 1'b1;
      page_word  <= w;
      @(posedge clock);
      page_valid <= 1'b0;
      page_word  <= ~w;
   endtask

   // which is {fault, 100, 10}
   task automatic pulse(input logic [2:0] which);
      @(posedge clock);
      {pd_fault, pd_link_100, pd_link_10} <= which;
      @(posedge clock);
      {pd_fault, pd_link_100, pd_link_10} <= 3'h0;
   endtask
endmodule // link_partner_model

// >>> bench/tb_phy_strap_autoneg_config.sv
// self-checking bench of the strap and negotiation configuration block
`timescale 1ns/1ps
module tb_phy_strap_autoneg_config
   import phy_cfg_pkg::*;
;
   logic         clock, rst, psel, penable, pwrite, wire_activity;
   logic         pready, pslverr, single_clock_mii, auto_crossover, low_power;
   logic         refclk_out, refclk_out_oe, flp_enable, restart_pulse, isolate;
   logic         link_ok, page_valid, pd_link_100, pd_link_10, pd_fault, e, r0;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic [15:0]  page_word, adv_word;
   logic [1:0]   lamp_cfg;
   strap_type    strap_pins;
   mac_mode_type mac_mode;
   op_mode_type  op_mode;
   int           err_count, comparisons, cycles;
   logic [15:0]  pw [4] = '{16'h01e1, 16'h00e1, 16'h0061, 16'h0021};
   logic [1:0]   om [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
   logic [3:0]   av [4] = '{4'h3, 4'hc, 4'h5, 4'hf};

   phy_strap_autoneg_config phy_strap_autoneg_config_i (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .strap_pins(strap_pins), .wire_activity(wire_activity), .link_ok(link_ok),
      .page_valid(page_valid), .page_word(page_word), .pd_link_100(pd_link_100),
      .pd_link_10(pd_link_10), .pd_fault(pd_fault), .mac_mode(mac_mode),
      .single_clock_mii(single_clock_mii), .lamp_cfg(lamp_cfg),
      .auto_crossover(auto_crossover), .low_power(low_power), .refclk_out(refclk_out),
      .refclk_out_oe(refclk_out_oe), .flp_enable(flp_enable), .adv_word(adv_word),
      .restart_pulse(restart_pulse), .isolate(isolate), .op_mode(op_mode));
   link_partner_model link_partner_model_i (.clock(clock), .link_ok(link_ok),
      .page_valid(page_valid), .page_word(page_word), .pd_link_100(pd_link_100),
      .pd_link_10(pd_link_10), .pd_fault(pd_fault));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // a hang counts as a mismatch and closes the run
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         final_report();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      e  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0000_0000);
      check(nm, rd, exp);
   endtask

   // straps toggle after release, since the pins then carry other traffic
   task automatic do_reset(input strap_type s);
      @(posedge clock);
      rst        <= 1'b1;
      strap_pins <= s;
      repeat (10) @(posedge clock);
      rst        <= 1'b0;
      strap_pins <= ~s;
      repeat (2) @(posedge clock);
      #1;
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      strap_pins = '0;
      wire_activity = 1'b0;
      // rmii with extender, never serial with extender
      do_reset(10'h2be);
      check("mac_mode", mac_mode, MAC_RMII);
      check("single_clock", single_clock_mii, 1'b0);
      check("lamp", lamp_cfg[0], 1'b1);
      check("xover", auto_crossover, 1'b0);
      check("low_power", low_power, 1'b1);
      check("refclk_oe", refclk_out_oe, 1'b0);
      check("adv_bits", adv_word[8:5], 4'h5);
      check("flp", flp_enable, 1'b1);
      rchk("status", IDX_STATUS, 32'h0000_7849);
      rchk("control", IDX_CTRL, 32'h0000_3100);
      wire_activity <= 1'b1;
      repeat (5) @(posedge clock);
      check("low_power", low_power, 1'b0);
      bus(1'b1, IDX_PORT_CFG, 32'h0000_c040);
      #1;
      check("lamp", lamp_cfg, 2'h2);
      check("xover", auto_crossover, 1'b1);
      bus(1'b0, 6'h02, 32'h0000_0000);
      check("slverr", e, 1'b1);
      bus(1'b1, IDX_ADV, 32'h0000_01e1);
      rchk("adv", IDX_ADV, 32'h0000_01e1);
      check("adv_word", adv_word, 16'h01e1);
      link_partner_model_i.set_link(1'b1);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, IDX_CTRL, 32'h0000_1200);
         #1;
         check("restart", restart_pulse, 1'b1);
         check("flp", flp_enable, 1'b0);
         link_partner_model_i.send_page((i < 4) ? pw[i] : 16'h21e1);
         repeat (2) @(posedge clock);
         check("op_mode", op_mode, {1'b1, (i < 4) ? om[i] : 2'h3});
      end
      rchk("status", IDX_STATUS, 32'h0000_787d);
      rchk("link", IDX_LINK, 32'h0000_0015);
      bus(1'b1, IDX_PARTNER, 32'h0000_0000);
      rchk("partner", IDX_PARTNER, 32'h0000_21e1);
      rchk("expansion", IDX_EXPANSION, 32'h0000_0007);
      rchk("expansion", IDX_EXPANSION, 32'h0000_0005);
      bus(1'b1, IDX_CTRL, 32'h0000_1200);
      link_partner_model_i.pulse(3'h2);
      rchk("partner", IDX_PARTNER, {16'h0000, PD_WORD_100});
      check("op_mode", op_mode, 3'h6);
      link_partner_model_i.pulse(3'h1);
      link_partner_model_i.pulse(3'h4);
      rchk("partner", IDX_PARTNER, 32'h0000_0021);
      bus(1'b0, IDX_EXPANSION, 32'h0000_0000);
      check("pd_fault", rd[4], 1'b1);
      check("partner_able", rd[0], 1'b0);
      bus(1'b1, IDX_CTRL, 32'h0000_2500);
      #1;
      check("op_mode", op_mode, 3'h7);
      check("isolate", isolate, 1'b1);
      bus(1'b1, IDX_CTRL, 32'h0000_3000);
      #1;
      check("op_mode", op_mode, 3'h4);
      do_reset(10'h343);
      check("mac_mode", mac_mode, MAC_SERIAL);
      check("op_mode", op_mode, 3'h7);
      check("lamp", lamp_cfg[0], 1'b0);
      check("refclk_oe", refclk_out_oe, 1'b1);
      r0 = refclk_out;
      @(posedge clock);
      #1;
      check("refclk", refclk_out, {31'h0000_0000, ~r0});
      for (int a = 0; a < 4; a++) begin
         do_reset(strap_type'(10'h0c8 | 10'(a)));
         check("op_mode", op_mode, {1'b1, 2'(a)});
         do_reset(strap_type'(10'h0cc | 10'(a)));
         check("adv_bits", adv_word[8:5], av[a]);
      end
      check("mac_mode", mac_mode, MAC_MII);
      check("single_clock", single_clock_mii, 1'b1);
      final_report();
   end
endmodule // tb_phy_strap_autoneg_config
